//--- rtl/swpsa_pkg.sv
// Shared constants for the sector write-protect and system-area block
package swpsa_pkg;
  // Serial byte locations (chip_enable_bit_two = 1)
  localparam logic [12:0] LOCK_LOW_OFS = 13'h800;
  localparam logic [12:0] LOCK_HIGH_OFS = 13'h804;
  localparam logic [12:0] SER_PW_OFS = 13'h900;
  localparam logic [12:0] RF_PW1_OFS = 13'h904;
  localparam logic [12:0] RF_PW2_OFS = 13'h908;
  localparam logic [12:0] RF_PW3_OFS = 13'h90C;
  localparam logic [12:0] IDS_OFS = 13'h910;
  localparam logic [12:0] UID_LOW_OFS = 13'h914;
  localparam logic [12:0] UID_HIGH_OFS = 13'h918;
  localparam logic [12:0] SIZE_REF_OFS = 13'h91C;
  // Byte lanes inside the identifier word
  localparam logic [1:0] AFI_LANE = 2'h2;
  localparam logic [1:0] STORAGE_FORMAT_IDENTIFIER_LANE = 2'h3;
  // User memory: 64 sectors of 128 bytes
  localparam int SECTOR_LSB = 7;
  localparam int SECTORS = 64;
  // Sector security byte fields
  localparam int SSS_LOCK_BIT = 0;
  localparam int SSS_PROT_LSB = 1;
  localparam int SSS_PSEL_LSB = 3;
  localparam logic [1:0] PROT_RO = 2'h0;
  localparam logic [1:0] PROT_RW = 2'h1;
  localparam logic [1:0] PROT_NONE = 2'h2;
  localparam logic [1:0] PROT_LOCKED = 2'h3;
  localparam logic [1:0] PSEL_NONE = 2'h0;
  // Serial password command validation codes
  localparam logic [7:0] PW_CMD_PRESENT = 8'h09;
  localparam logic [7:0] PW_CMD_WRITE = 8'h07;
  // Delivery values
  localparam logic [63:0] LOCK_RST = 64'h0000_0000_0000_0000;
  localparam logic [31:0] PW_RST = 32'h0000_0000;
  localparam logic [7:0] AFI_RST = 8'h00;
  localparam logic [7:0] STORAGE_FORMAT_IDENTIFIER_RST = 8'hFF;
  localparam logic [23:0] MEM_SIZE = 24'h0307FF;
  // Access sequencer states, Gray coded
  typedef enum logic [1:0]
  {
    ACC_IDLE = 2'b00,
    ACC_EVAL = 2'b01,
    ACC_RESP = 2'b11
  } swpsa_acc_e;
endpackage

//--- rtl/swpsa_rf_rights.sv
// Contactless access rights of one sector from its security byte
`timescale 1ns/100ps
module swpsa_rf_rights
  import swpsa_pkg::*;
(
  // Sector security byte
  input wire logic [7:0] status_byte,
  // Passwords currently granted, bit 0 = password one
  input wire logic [2:0] granted,
  // Rights
  output logic read_ok,
  output logic write_ok
);
  logic locked;
  logic [1:0] prot;
  logic [1:0] psel;
  logic linked;

  assign locked = status_byte[SSS_LOCK_BIT];
  assign prot = status_byte[SSS_PROT_LSB +: 2];
  assign psel = status_byte[SSS_PSEL_LSB +: 2];
  assign linked = (psel != PSEL_NONE) && granted[psel - 2'h1];

  always_comb
  begin
    if (!locked)
    begin
      read_ok = 1'b1;
      write_ok = 1'b1;
    end
    else if (linked)
    begin
      read_ok = 1'b1;
      write_ok = (prot != PROT_LOCKED);
    end
    else
    begin
      // Unlinked sectors keep the power-up rights
      read_ok = (prot == PROT_RO) || (prot == PROT_RW);
      write_ok = (prot == PROT_RW);
    end
  end
endmodule

//--- rtl/swpsa_core.sv
// Serial write-lock, password gating and system-area access logic
`timescale 1ns/100ps
// Summary of operation
// - A set write-lock bit blocks serial writes to its sector; clear permits them.
// - Eight write-lock bytes from location 2048 hold one bit per sector, 64 sectors.
// - Word 2048 holds sectors 0-31, word 2052 sectors 32-63, low byte lowest.
// - Clearing a write-lock bit over the serial side is always allowed.
// - Lock bytes always readable; setting them needs a presented serial password.
// - At delivery all write-lock bytes are zero, every sector unprotected.
// - The 32-bit serial password lives at location 2304.
// - After power-on locked sectors read freely but refuse writes until unlocked.
// - Presentation is correct only when all 32 bits match; it lifts write locks.
// - The serial password may be changed only after it has been presented.
// - Contactless passwords at 2308, 2312, 2316 are hidden from the serial side.
// - Family identifier at 2322 and format identifier at 2323 are read-only.
// - A read-only 64-bit unique identifier occupies eight bytes from 2324.
// - Bytes 2332 to 2335 hold chip reference (lowest byte) and memory size.
// - Delivery: all passwords zero, format identifier FFh, family identifier 00h.
// - Locked sector without password: 00 read only, 01 read-write, 10/11 nothing.
// - Password one grants read-write for 00/01/10, read only for 11.
// - Security byte: bit 0 lock, bits 2:1 protection, bits 4:3 password select.
// - A wrong contactless password withdraws all granted access rights.
module swpsa_core
  import swpsa_pkg::*;
#(
  // Arbitrary identity values
  parameter logic [63:0] UNIQUE_IDENTIFIER = 64'h0123_4567_89AB_CDEF,
  parameter logic [7:0] CHIP_REFERENCE_CODE = 8'h5A
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial byte access from the bus front end
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic chip_enable_bit_two,
  input wire logic [12:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  output logic acc_busy,
  output logic acc_done,
  output logic acc_ok,
  output logic [7:0] acc_rdata,
  // Serial password commands
  input wire logic pw_cmd_valid,
  input wire logic [7:0] pw_cmd_code,
  input wire logic [31:0] pw_first,
  input wire logic [31:0] pw_second,
  output logic pw_done,
  output logic pw_accepted,
  output logic serial_pw_presented,
  // Contactless password commands
  input wire logic rf_present_valid,
  input wire logic [1:0] rf_present_index,
  input wire logic [31:0] rf_present_value,
  input wire logic rf_pw_write_valid,
  input wire logic [1:0] rf_pw_write_index,
  input wire logic [31:0] rf_pw_write_value,
  output logic [2:0] rf_granted,
  // Contactless sector rights query
  input wire logic [7:0] rf_sector_status,
  output logic rf_read_allowed,
  output logic rf_write_allowed
);
  // Persistent storage, loaded with delivery values on reset
  logic [63:0] lock_reg;
  logic [31:0] ser_pw_reg;
  logic [31:0] rf_pw_reg [3];
  logic presented_reg;
  logic [2:0] granted_reg;

  swpsa_acc_e state_reg;
  logic write_reg;
  logic e2_reg;
  logic [12:0] addr_reg;
  logic [7:0] wdata_reg;
  logic busy_reg;
  logic done_reg;
  logic ok_reg;
  logic [7:0] rdata_reg;
  logic pw_done_reg;
  logic pw_acc_reg;
  logic rf_rd_reg;
  logic rf_wr_reg;

  logic [12:0] word_addr;
  logic [1:0] lane;
  logic is_lock;
  logic [2:0] lock_byte_idx;
  logic [7:0] lock_byte;
  logic [5:0] sector;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [7:0] lock_byte_next;
  logic pw_copies_same;
  logic rf_rd_ok;
  logic rf_wr_ok;

  assign word_addr = {addr_reg[12:2], 2'b00};
  assign lane = addr_reg[1:0];
  assign is_lock = e2_reg && ((word_addr == LOCK_LOW_OFS) || (word_addr == LOCK_HIGH_OFS));
  assign lock_byte_idx = {addr_reg[2], addr_reg[1:0]};
  assign lock_byte = lock_reg[lock_byte_idx * 8 +: 8];
  assign sector = addr_reg[SECTOR_LSB +: 6];
  assign pw_copies_same = (pw_first == pw_second);

  // Read word and permissions for the latched access
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    lock_byte_next = lock_byte;
    if (!e2_reg)
    begin
      // User memory: the array itself sits outside this block
      rd_ok = 1'b1;
      wr_ok = !lock_reg[sector] || presented_reg;
    end
    else
    begin
      case (word_addr)
        LOCK_LOW_OFS, LOCK_HIGH_OFS:
        begin
          rd_word = addr_reg[2] ? lock_reg[63:32] : lock_reg[31:0];
          rd_ok = 1'b1;
          if (presented_reg)
          begin
            lock_byte_next = acc_wdata_mux(wdata_reg);
            wr_ok = 1'b1;
          end
          else
          begin
            // Clearing is honoured even when locked; setting bits is dropped
            lock_byte_next = lock_byte & wdata_reg;
            wr_ok = ((wdata_reg & ~lock_byte) == 8'h00);
          end
        end
        SER_PW_OFS:
        begin
          // Direct byte writes never touch the password; commands do
          rd_word = ser_pw_reg;
          rd_ok = presented_reg;
        end
        RF_PW1_OFS, RF_PW2_OFS, RF_PW3_OFS:
        begin
          rd_ok = 1'b0;
        end
        IDS_OFS:
        begin
          rd_word = {STORAGE_FORMAT_IDENTIFIER_RST, AFI_RST, 16'h0000};
          rd_ok = 1'b1;
        end
        UID_LOW_OFS:
        begin
          rd_word = UNIQUE_IDENTIFIER[31:0];
          rd_ok = 1'b1;
        end
        UID_HIGH_OFS:
        begin
          rd_word = UNIQUE_IDENTIFIER[63:32];
          rd_ok = 1'b1;
        end
        SIZE_REF_OFS:
        begin
          rd_word = {MEM_SIZE, CHIP_REFERENCE_CODE};
          rd_ok = 1'b1;
        end
        default:
        begin
          rd_ok = 1'b0;
        end
      endcase
    end
  end

  function automatic logic [7:0] acc_wdata_mux(input logic [7:0] d);
    acc_wdata_mux = d;
  endfunction

  // Access sequencer: take, evaluate, answer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ACC_IDLE;
      write_reg <= 1'b0;
      e2_reg <= 1'b0;
      addr_reg <= 13'h0000;
      wdata_reg <= 8'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      ok_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      case (state_reg)
        ACC_IDLE:
        begin
          done_reg <= 1'b0;
          if (acc_req)
          begin
            write_reg <= acc_write;
            e2_reg <= chip_enable_bit_two;
            addr_reg <= acc_addr;
            wdata_reg <= acc_wdata;
            busy_reg <= 1'b1;
            state_reg <= ACC_EVAL;
          end
        end
        ACC_EVAL:
        begin
          done_reg <= 1'b1;
          ok_reg <= write_reg ? wr_ok : rd_ok;
          // Refused reads return zero so hidden data never leaks
          rdata_reg <= (!write_reg && rd_ok) ? rd_word[lane * 8 +: 8] : 8'h00;
          state_reg <= ACC_RESP;
        end
        ACC_RESP:
        begin
          done_reg <= 1'b0;
          busy_reg <= 1'b0;
          state_reg <= ACC_IDLE;
        end
        default:
        begin
          done_reg <= 1'b0;
          busy_reg <= 1'b0;
          state_reg <= ACC_IDLE;
        end
      endcase
    end
  end

  // Write-lock storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_reg <= LOCK_RST;
    end
    else if ((state_reg == ACC_EVAL) && write_reg && is_lock)
    begin
      lock_reg[lock_byte_idx * 8 +: 8] <= lock_byte_next;
    end
  end

  // Serial password present and write commands
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_pw_reg <= PW_RST;
      presented_reg <= 1'b0;
      pw_done_reg <= 1'b0;
      pw_acc_reg <= 1'b0;
    end
    else
    begin
      pw_done_reg <= 1'b0;
      if (pw_cmd_valid)
      begin
        pw_done_reg <= 1'b1;
        pw_acc_reg <= 1'b0;
        // A mismatch between the two copies aborts without any effect
        if (pw_copies_same && (pw_cmd_code == PW_CMD_PRESENT))
        begin
          presented_reg <= (pw_first == ser_pw_reg);
          pw_acc_reg <= (pw_first == ser_pw_reg);
        end
        else if (pw_copies_same && (pw_cmd_code == PW_CMD_WRITE) && presented_reg)
        begin
          ser_pw_reg <= pw_first;
          pw_acc_reg <= 1'b1;
        end
      end
    end
  end

  // Contactless password storage, one entry per password
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_rf_pw
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rf_pw_reg[gi] <= PW_RST;
        end
        else if (rf_pw_write_valid && (rf_pw_write_index == 2'(gi + 1)) && granted_reg[gi])
        begin
          rf_pw_reg[gi] <= rf_pw_write_value;
        end
      end
    end
  endgenerate

  // Contactless presentation: a new command replaces earlier grants
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      granted_reg <= 3'b000;
    end
    else if (rf_present_valid)
    begin
      if ((rf_present_index != PSEL_NONE)
          && (rf_present_value == rf_pw_reg[rf_present_index - 2'h1]))
      begin
        granted_reg <= 3'(1 << (rf_present_index - 2'h1));
      end
      else
      begin
        granted_reg <= 3'b000;
      end
    end
  end

  swpsa_rf_rights u_rf_rights
  (
    .status_byte(rf_sector_status),
    .granted(granted_reg),
    .read_ok(rf_rd_ok),
    .write_ok(rf_wr_ok)
  );

  // Registered rights answer, one cycle after the query
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_rd_reg <= 1'b0;
      rf_wr_reg <= 1'b0;
    end
    else
    begin
      rf_rd_reg <= rf_rd_ok;
      rf_wr_reg <= rf_wr_ok;
    end
  end

  assign acc_busy = busy_reg;
  assign acc_done = done_reg;
  assign acc_ok = ok_reg;
  assign acc_rdata = rdata_reg;
  assign pw_done = pw_done_reg;
  assign pw_accepted = pw_acc_reg;
  assign serial_pw_presented = presented_reg;
  assign rf_granted = granted_reg;
  assign rf_read_allowed = rf_rd_reg;
  assign rf_write_allowed = rf_wr_reg;
endmodule

//--- bench/swpsa_core_chk.sv
// Port assertions for the access-control core
`timescale 1ns/100ps
module swpsa_core_chk
  import swpsa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Byte access
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic chip_enable_bit_two,
  input wire logic [12:0] acc_addr,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic acc_ok,
  input wire logic [7:0] acc_rdata,
  // Commands and rights
  input wire logic pw_cmd_valid,
  input wire logic [7:0] pw_cmd_code,
  input wire logic pw_done,
  input wire logic pw_accepted,
  input wire logic serial_pw_presented,
  input wire logic rf_present_valid,
  input wire logic [1:0] rf_present_index,
  input wire logic [2:0] rf_granted,
  input wire logic [7:0] rf_sector_status,
  input wire logic rf_read_allowed,
  input wire logic rf_write_allowed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take(c);
    acc_req && !acc_busy && !acc_done && c;
  endsequence
  sequence s_ans(k);
    ##2 acc_done && acc_ok == k;
  endsequence
  sequence s_busy_walk;
    acc_busy && !acc_done ##1 acc_busy && acc_done ##1 !acc_busy && !acc_done;
  endsequence
  a_busy_spans_answer: assert property (
    s_take(1'h1) |=> s_busy_walk) else $error("busy window wrong");
  a_hidden_pw_refused: assert property (
    s_take(chip_enable_bit_two && acc_addr inside {[13'h904:13'h90F]})
    |-> s_ans(1'h0) ##0 acc_rdata == 8'h00) else $error("hidden password reached");
  a_sysarea_read_only: assert property (
    s_take(chip_enable_bit_two && acc_write && acc_addr inside {[13'h910:13'h91F]})
    |-> s_ans(1'h0)) else $error("system area write accepted");
  a_format_id_value: assert property (
    s_take(chip_enable_bit_two && !acc_write && acc_addr == 13'h913)
    |-> s_ans(1'h1) ##0 acc_rdata == STORAGE_FORMAT_IDENTIFIER_RST) else $error("format identifier wrong");
  a_lock_read_ok: assert property (
    s_take(chip_enable_bit_two && !acc_write && acc_addr[12:3] == 10'h100)
    |-> s_ans(1'h1)) else $error("lock byte read refused");
  a_user_read_ok: assert property (
    s_take(!chip_enable_bit_two && !acc_write) |-> s_ans(1'h1)) else $error("user read refused");
  a_unlocked_write_ok: assert property (
    s_take(!chip_enable_bit_two && acc_write && serial_pw_presented)
    |-> s_ans(1'h1)) else $error("write refused after presentation");
  a_pw_update_gate: assert property (
    pw_cmd_valid && pw_cmd_code == PW_CMD_WRITE && !serial_pw_presented
    |=> pw_done && !pw_accepted) else $error("password changed unpresented");
  a_rf_wrong_clears: assert property (
    rf_present_valid && rf_present_index == 2'h0 |=> rf_granted == 3'h0)
    else $error("grant kept after wrong password");
  a_rf_no_access: assert property (
    rf_sector_status[0] && rf_sector_status[2] && rf_granted == 3'h0
    |=> !rf_read_allowed && !rf_write_allowed) else $error("locked sector accessible");
endmodule
bind swpsa_core swpsa_core_chk swpsa_core_chk_i (.clk, .rst_n, .acc_req, .acc_write,
  .chip_enable_bit_two, .acc_addr, .acc_busy, .acc_done, .acc_ok, .acc_rdata, .pw_cmd_valid,
  .pw_cmd_code, .pw_done, .pw_accepted, .serial_pw_presented, .rf_present_valid,
  .rf_present_index, .rf_granted, .rf_sector_status, .rf_read_allowed, .rf_write_allowed);

//--- bench/swpsa_bus_master.sv
// Two-wire bus master model issuing byte accesses
`timescale 1ns/100ps
module swpsa_bus_master
(
  // Clock and answer
  input wire logic clk,
  input wire logic acc_done,
  input wire logic acc_ok,
  input wire logic [7:0] acc_rdata,
  // Request
  output logic acc_req,
  output logic acc_write,
  output logic chip_enable_bit_two,
  output logic [12:0] acc_addr,
  output logic [7:0] acc_wdata
);
  initial
  begin
    {acc_req, acc_write, chip_enable_bit_two, acc_addr, acc_wdata} = '0;
  end
  task automatic access(logic w, logic c, logic [12:0] a, logic [7:0] d,
    output logic ok, output logic [7:0] rd);
    int n;
    n = 0;
    {acc_write, chip_enable_bit_two, acc_addr, acc_wdata} = {w, c, a, d};
    acc_req = 1'h1;
    // Request stands until the falling edge after the one that samples the answer pulse
    @(negedge clk);
    while (acc_done !== 1'h1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    ok = acc_done === 1'h1 ? acc_ok : 1'hx;
    rd = acc_rdata;
    @(negedge clk);
    // Released lines show the inverse so a stale value cannot pass
    {acc_req, acc_addr, acc_wdata} = {1'h0, ~a, ~d};
    @(negedge clk);
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the access-control core
`timescale 1ns/100ps
module testbench
  import swpsa_pkg::*;
;
  localparam logic [63:0] UID_V = 64'h1122_3344_5566_7788; // Arbitrary value
  localparam logic [7:0] REF_V = 8'hA5; // Arbitrary value
  logic clk, rst_n, acc_req, acc_write, chip_enable_bit_two, acc_busy, acc_done, acc_ok;
  logic pw_cmd_valid, pw_done, pw_accepted, serial_pw_presented, rf_present_valid;
  logic rf_read_allowed, rf_write_allowed, ok, m_pres;
  logic [12:0] acc_addr;
  logic [7:0] acc_wdata, acc_rdata, pw_cmd_code, rf_sector_status, rd;
  logic [31:0] pw_first, pw_second, rf_present_value, m_pw, pn;
  logic [1:0] rf_present_index;
  logic [2:0] rf_granted, m_gr;
  logic [63:0] m_lock;
  int bad_count, checks;
  swpsa_core #(.UNIQUE_IDENTIFIER(UID_V), .CHIP_REFERENCE_CODE(REF_V)) swpsa_core_i (.clk,
    .rst_n, .acc_req, .acc_write, .chip_enable_bit_two, .acc_addr, .acc_wdata, .acc_busy,
    .acc_done, .acc_ok, .acc_rdata, .pw_cmd_valid, .pw_cmd_code, .pw_first, .pw_second,
    .pw_done, .pw_accepted, .serial_pw_presented, .rf_present_valid, .rf_present_index,
    .rf_present_value, .rf_pw_write_valid(1'h0), .rf_pw_write_index(2'h0),
    .rf_pw_write_value(32'h0000_0000), .rf_granted, .rf_sector_status, .rf_read_allowed,
    .rf_write_allowed);
  swpsa_bus_master swpsa_bus_master_i (.clk, .acc_done, .acc_ok, .acc_rdata, .acc_req,
    .acc_write, .chip_enable_bit_two, .acc_addr, .acc_wdata);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (e !== s)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(logic w, logic c, logic [12:0] a, logic [7:0] d);
    logic [127:0] sys;
    logic [7:0] old, erd;
    logic eok;
    sys = {MEM_SIZE, REF_V, UID_V, STORAGE_FORMAT_IDENTIFIER_RST, AFI_RST, 16'h0000};
    old = m_lock[{a[2:0], 3'h0} +: 8];
    {eok, erd} = 9'h000;
    if (!c)
      eok = !w || !m_lock[a[12:7]] || m_pres;
    else if (a[12:3] == 10'h100)
    begin
      {eok, erd} = {!w || m_pres || (d & ~old) == 8'h00, w ? 8'h00 : old};
      if (w)
        m_lock[{a[2:0], 3'h0} +: 8] = m_pres ? d : old & d;
    end
    else if (!w && a[12:2] == 11'h240 && m_pres)
      {eok, erd} = {1'h1, m_pw[{a[1:0], 3'h0} +: 8]};
    else if (!w && a[12:4] == 9'h091)
      {eok, erd} = {1'h1, sys[{a[3:0], 3'h0} +: 8]};
    swpsa_bus_master_i.access(w, c, a, d, ok, rd);
    chk("acc_ok", eok, ok);
    if (w || c)
      chk("acc_rdata", erd, rd);
  endtask
  // Every lock and system byte: read, random write, read back
  task automatic sweep;
    logic [12:0] a;
    for (int k = 0; k < 48; k++)
    begin
      a = k < 16 ? 13'h800 + 13'(k) : 13'h8F0 + 13'(k);
      acc(1'h0, 1'h1, a, 8'h00);
      acc(1'h1, 1'h1, a, 8'($urandom));
      acc(1'h0, 1'h1, a, 8'h00);
    end
  endtask
  task automatic user_rnd;
    for (int k = 0; k < 40; k++)
    begin
      acc(1'h1, 1'h0, 13'($urandom), 8'($urandom));
      acc(1'h0, 1'h0, 13'($urandom), 8'h00);
    end
  endtask
  task automatic pw(logic [7:0] c, logic [31:0] x, logic [31:0] y);
    logic e;
    e = x == y && (c == PW_CMD_PRESENT ? x == m_pw : c == PW_CMD_WRITE && m_pres);
    if (x == y && c == PW_CMD_PRESENT)
      m_pres = x == m_pw;
    if (e && c == PW_CMD_WRITE)
      m_pw = x;
    {pw_cmd_code, pw_first, pw_second, pw_cmd_valid} = {c, x, y, 1'h1};
    @(negedge clk);
    pw_cmd_valid = 1'h0;
    chk("pw_done", 1'h1, pw_done);
    chk("pw_accepted", e, pw_accepted);
    chk("presented", m_pres, serial_pw_presented);
    @(negedge clk);
  endtask
  function automatic logic [1:0] rights(logic [7:0] s, logic [2:0] g);
    logic hit;
    hit = s[4:3] != 2'h0 && g[s[4:3] - 2'h1];
    if (!s[0])
      return 2'h3;
    if (hit)
      return {1'h1, s[2:1] != 2'h3};
    return {!s[2], s[2:1] == 2'h1};
  endfunction
  // Contactless passwords stay at their zero delivery value
  task automatic rf(logic [1:0] i, logic [31:0] v);
    logic [1:0] er;
    {rf_present_index, rf_present_value, rf_present_valid} = {i, v, 1'h1};
    m_gr = i != 2'h0 && v == 32'h0 ? 3'h1 << (i - 2'h1) : 3'h0;
    @(negedge clk);
    rf_present_valid = 1'h0;
    chk("rf_granted", m_gr, rf_granted);
    for (int k = 0; k < 32; k++)
    begin
      rf_sector_status = {3'($urandom), 5'(k)};
      @(negedge clk);
      er = rights(rf_sector_status, m_gr);
      chk("rf rights", er, {rf_read_allowed, rf_write_allowed});
    end
  endtask
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #200000;
    bad_count++;
    stop_test;
  end
  initial
  begin
    {rst_n, pw_cmd_valid, rf_present_valid, pw_cmd_code, pw_first, pw_second} = '0;
    {rf_present_index, rf_present_value, rf_sector_status, m_gr} = '0;
    {m_pres, m_pw, m_lock, bad_count, checks} = '0;
    void'($urandom(64755));
    pn = $urandom;
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    sweep;
    $display("test delivery state done");
    pw(PW_CMD_WRITE, 32'h5, 32'h5);
    pw(PW_CMD_PRESENT, 32'h1, 32'h1);
    pw(PW_CMD_PRESENT, 32'h0, 32'h1);
    pw(8'h55, 32'h0, 32'h0);
    pw(PW_CMD_PRESENT, 32'h0, 32'h0);
    pw(PW_CMD_WRITE, 32'h7, 32'h8);
    pw(PW_CMD_WRITE, pn, pn);
    sweep;
    $display("test password done");
    user_rnd;
    pw(PW_CMD_PRESENT, pn ^ 32'h8000_0000, pn ^ 32'h8000_0000);
    user_rnd;
    sweep;
    pw(PW_CMD_PRESENT, pn, pn);
    user_rnd;
    $display("test write lock done");
    rf(2'h0, 32'h0);
    rf(2'h1, 32'h0);
    rf(2'h2, 32'h1);
    rf(2'h3, 32'h0);
    $display("test contactless rights done");
    stop_test;
  end
endmodule
